// ---- design/tcp_pkg.sv ----
// package for the timer compare/pwm output block
package tcp_pkg;
   localparam int TCP_NCH = 6;
   localparam int TCP_CW = 16;
   localparam int TCP_AW = 5;
   localparam logic [5:0] TCP_CLK_MHZ = 6'h32;
   // register map: word offsets on the plain port
   localparam logic [4:0] TCP_OFS_TIMER_CTRL = 5'h00;
   localparam logic [4:0] TCP_OFS_TIMER_STAT = 5'h01;
   localparam logic [4:0] TCP_OFS_MODULO = 5'h02;
   localparam logic [4:0] TCP_OFS_COUNT = 5'h03;
   localparam logic [4:0] TCP_OFS_CH_CTRL = 5'h08;
   localparam logic [4:0] TCP_OFS_CH_VAL = 5'h10;
   localparam logic [4:0] TCP_OFS_ACTIVE = 5'h18;
   // timer control and status fields
   localparam int TCP_TC_STOP = 0;
   localparam int TCP_TC_RST = 1;
   localparam int TCP_TC_PS_LO = 2;
   localparam int TCP_TC_OVIE = 5;
   localparam int TCP_TS_OVF = 0;
   // channel control fields
   localparam int TCP_CC_MAX = 0;
   localparam int TCP_CC_TOV = 1;
   localparam int TCP_CC_ELSA = 2;
   localparam int TCP_CC_ELSB = 3;
   localparam int TCP_CC_MODE_LO = 4;
   localparam int TCP_CC_LINK = 5;
   localparam int TCP_CC_IE = 6;
   localparam int TCP_CC_FLAG = 7;
   localparam logic [15:0] TCP_MOD_RST = 16'hFFFF;
   localparam logic [15:0] TCP_ZERO16 = 16'h0000;
   localparam logic [15:0] TCP_ONE16 = 16'h0001;
   localparam logic [7:0] TCP_ZERO8 = 8'h00;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } tcp_bus_s;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [15:0] val;
   } tcp_chan_s;

   // edge/level select action on a compare match
   typedef enum logic [1:0] {
      TCP_ACT_NONE = 2'b00,
      TCP_ACT_TOGGLE = 2'b01,
      TCP_ACT_CLEAR = 2'b10,
      TCP_ACT_SET = 2'b11
   } tcp_act_e;

   function automatic tcp_act_e tcp_action(input logic [7:0] c);
      return tcp_act_e'({c[TCP_CC_ELSB], c[TCP_CC_ELSA]});
   endfunction : tcp_action
endpackage : tcp_pkg

// ---- design/tcp_counter.sv ----
// shared modulo counter with prescaler
`timescale 1ns/100ps
module tcp_counter
   import tcp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // control
   input wire logic stop_i,
   input wire logic clr_i,
   input wire logic [2:0] ps_i,
   input wire logic [15:0] modulo_i,
   // status
   output logic [15:0] count_o,
   output logic tick_o,
   output logic ovf_o
);
   typedef struct packed {
      logic [6:0] pre;
      logic [15:0] cnt;
   } tcp_cnt_s;

   tcp_cnt_s st;
   tcp_cnt_s next_st;
   logic [6:0] pre_mask;

   always_comb begin
      next_st = st;
      pre_mask = 7'((8'h01 << ps_i) - 8'h01);
      tick_o = !stop_i && ((st.pre & pre_mask) == pre_mask);
      ovf_o = tick_o && (st.cnt == modulo_i);
      if (!stop_i) begin
         next_st.pre = st.pre + 7'h01;
      end
      if (tick_o) begin
         next_st.cnt = ovf_o ? TCP_ZERO16 : st.cnt + TCP_ONE16;
      end
      if (clr_i) begin
         next_st.pre = 7'h00;
         next_st.cnt = TCP_ZERO16;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign count_o = st.cnt;
endmodule : tcp_counter

// ---- design/tcp_pair_sel.sv ----
// linked pair: which register set controls the output
`timescale 1ns/100ps
module tcp_pair_sel
   import tcp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // events
   input wire logic link_i,
   input wire logic wr_lo_i,
   input wire logic wr_hi_i,
   input wire logic ovf_i,
   // selection
   output logic use_hi_o
);
   typedef struct packed {
      logic use_hi;
      logic last_hi;
   } tcp_sel_s;

   tcp_sel_s st;
   tcp_sel_s next_st;

   always_comb begin
      next_st = st;
      // last written set
      // last written set wins; a lower write in the same cycle is later
      if (wr_hi_i) begin
         next_st.last_hi = 1'b1;
      end
      if (wr_lo_i) begin
         next_st.last_hi = 1'b0;
      end
      if (ovf_i) begin
         next_st.use_hi = next_st.last_hi;
      end
      if (!link_i) begin
         next_st.use_hi = 1'b0;
         next_st.last_hi = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign use_hi_o = st.use_hi;
endmodule : tcp_pair_sel

// ---- design/tcp_top.sv ----
// six-channel output compare and pwm unit of the timer
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
module tcp_top
   import tcp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // channel pins
   output logic [5:0] chan_pin_o,
   output logic [5:0] chan_pin_oe_o,
   // flags to the interrupt logic outside
   output logic ovf_irq_o,
   output logic [5:0] chan_irq_o
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      logic [5:0] tctrl;
      logic ovf_flag;
      logic [15:0] modulo;
      tcp_chan_s [5:0] ch;
      logic [5:0] pin;
      logic [15:0] rdata;
   } tcp_top_s;

   tcp_top_s st;
   tcp_top_s next_st;
   tcp_bus_s bus;
   logic [15:0] count;
   logic [15:0] count_nx;
   logic tick;
   logic ovf;
   logic [2:0] use_hi;
   logic [2:0] link;
   logic [5:0] wr_val;
   logic [5:0] wr_ctrl;
   logic [5:0] match;
   logic [5:0] pin_en;

   assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

   tcp_counter u_cnt (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .stop_i(st.tctrl[TCP_TC_STOP]),
      .clr_i(st.tctrl[TCP_TC_RST]),
      .ps_i(st.tctrl[TCP_TC_PS_LO +: 3]),
      .modulo_i(st.modulo),
      .count_o(count),
      .tick_o(tick),
      .ovf_o(ovf)
   );

   // -------------------------------------------------------------
   // per pair selection
   // -------------------------------------------------------------
   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++) begin : g_pair
         assign link[gp] = st.ch[2*gp].ctrl[TCP_CC_LINK];
         tcp_pair_sel u_sel (
            .sys_clk_i(sys_clk_i),
            .nrst_i(nrst_i),
            .link_i(link[gp]),
            .wr_lo_i(wr_val[2*gp]),
            .wr_hi_i(wr_val[2*gp+1]),
            .ovf_i(ovf),
            .use_hi_o(use_hi[gp])
         );
      end
   endgenerate

   // -------------------------------------------------------------
   // decode and compare
   // -------------------------------------------------------------
   always_comb begin
      // pin actions land as the counter takes the value, so a value of n gives n ticks
      count_nx = ovf ? TCP_ZERO16 : count + TCP_ONE16;
      for (int i = 0; i < TCP_NCH; i++) begin
         wr_val[i] = bus.wr && (bus.addr == TCP_OFS_CH_VAL + 5'(i));
         wr_ctrl[i] = bus.wr && (bus.addr == TCP_OFS_CH_CTRL + 5'(i));
      end
      for (int p = 0; p < 3; p++) begin
         // compare against the set in control
         match[2*p] = tick && (count_nx ==
            (use_hi[p] ? st.ch[2*p+1].val : st.ch[2*p].val));
         match[2*p+1] = tick && !link[p] && (count_nx == st.ch[2*p+1].val);
         pin_en[2*p] = 1'b1;
         pin_en[2*p+1] = !link[p];
      end
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      logic [7:0] c;
      logic p;
      c = TCP_ZERO8;
      p = 1'b0;
      next_st = st;
      // reset request is a one-shot pulse
      next_st.tctrl[TCP_TC_RST] = 1'b0;
      next_st.rdata = TCP_ZERO16;
      // overflow flag, set wins over clear
      if (bus.wr && bus.addr == TCP_OFS_TIMER_STAT && !bus.wdata[TCP_TS_OVF]) begin
         next_st.ovf_flag = 1'b0;
      end
      if (ovf) begin
         next_st.ovf_flag = 1'b1;
      end
      if (bus.wr && bus.addr == TCP_OFS_TIMER_CTRL) begin
         next_st.tctrl = bus.wdata[5:0];
      end
      if (bus.wr && bus.addr == TCP_OFS_MODULO) begin
         next_st.modulo = bus.wdata;
      end
      for (int i = 0; i < TCP_NCH; i++) begin
         c = st.ch[i].ctrl;
         // active set takes effect at once
         if (wr_val[i]) begin
            next_st.ch[i].val = bus.wdata;
         end
         if (wr_ctrl[i]) begin
            // flag is write-zero-to-clear
            next_st.ch[i].ctrl = {c[TCP_CC_FLAG] & bus.wdata[TCP_CC_FLAG], bus.wdata[6:0]};
            // link bit lives only on even channels
            if (i % 2 == 1) begin
               next_st.ch[i].ctrl[TCP_CC_LINK] = 1'b0;
            end
         end
         // channel flag at match, set wins
         if (match[i]) begin
            next_st.ch[i].ctrl[TCP_CC_FLAG] = 1'b1;
         end
      end
      // pin logic on every channel in compare mode, including the disabled odd channel of a linked pair
      for (int i = 0; i < TCP_NCH; i++) begin
         c = st.ch[i].ctrl;
         p = st.pin[i];
         // link implies output compare regardless of the mode bit
         if (c[TCP_CC_LINK] || c[TCP_CC_MODE_LO]) begin
            // overflow toggle applied before the compare
            if (ovf && c[TCP_CC_TOV]) begin
               p = !p;
            end
            // max bit with the overflow toggle bit set forces full duty by skipping the compare
            if (match[i] && !(c[TCP_CC_MAX] && c[TCP_CC_TOV])) begin
               case (tcp_action(c))
                  TCP_ACT_TOGGLE: p = !p;
                  TCP_ACT_CLEAR: p = 1'b0;
                  TCP_ACT_SET: p = 1'b1;
                  default: p = p;
               endcase
            end
            // max duty holds the active level
            if (c[TCP_CC_MAX] && c[TCP_CC_TOV]) begin
               p = (tcp_action(c) == TCP_ACT_CLEAR);
            end
         end
         next_st.pin[i] = p;
      end
      // reads
      if (bus.rd) begin
         case (bus.addr)
            TCP_OFS_TIMER_CTRL: next_st.rdata = {10'h000, st.tctrl};
            TCP_OFS_TIMER_STAT: next_st.rdata = {15'h0000, st.ovf_flag};
            TCP_OFS_MODULO: next_st.rdata = st.modulo;
            TCP_OFS_COUNT: next_st.rdata = count;
            TCP_OFS_ACTIVE: next_st.rdata = {13'h0000, use_hi};
            default: begin
               for (int i = 0; i < TCP_NCH; i++) begin
                  if (bus.addr == TCP_OFS_CH_CTRL + 5'(i)) begin
                     next_st.rdata = {8'h00, st.ch[i].ctrl};
                  end
                  if (bus.addr == TCP_OFS_CH_VAL + 5'(i)) begin
                     next_st.rdata = st.ch[i].val;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= '0;
         st.tctrl[TCP_TC_STOP] <= 1'b1;
         st.modulo <= TCP_MOD_RST;
      end else begin
         st <= next_st;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < TCP_NCH; i++) begin
         chan_pin_oe_o[i] = pin_en[i] &&
            (st.ch[i].ctrl[TCP_CC_LINK] || st.ch[i].ctrl[TCP_CC_MODE_LO]);
         chan_irq_o[i] = st.ch[i].ctrl[TCP_CC_FLAG] && st.ch[i].ctrl[TCP_CC_IE]
            && pin_en[i];
      end
   end

   assign chan_pin_o = st.pin;
   assign rdata_o = st.rdata;
   assign ovf_irq_o = st.ovf_flag && st.tctrl[TCP_TC_OVIE];
endmodule : tcp_top

// ---- verification/tcp_top_asserts.sv ----
// assertion checker for the timer compare/pwm output block
`timescale 1ns/100ps
module tcp_top_asserts
   import tcp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   // pins and flags
   input wire logic [5:0] chan_pin_o,
   input wire logic [5:0] chan_pin_oe_o,
   input wire logic ovf_irq_o,
   input wire logic [5:0] chan_irq_o
);
   // ----------------
   // written settings
   // ----------------
   // flag bit left out: hardware sets it, so a shadow of it would lie
   logic [5:0][6:0] csh;
   logic ovie;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         csh <= '0;
         ovie <= 1'b0;
      end else if (wr_i) begin
         if (addr_i >= TCP_OFS_CH_CTRL && addr_i < TCP_OFS_CH_CTRL + 5'd6) begin
            csh[addr_i[2:0]] <= wdata_i[6:0];
         end
         if (addr_i == TCP_OFS_TIMER_CTRL) begin
            ovie <= wdata_i[TCP_TC_OVIE];
         end
      end
   end
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // ----------
   // properties
   // ----------
   property p_rd_idle;
      !$past(rd_i) |-> rdata_o == TCP_ZERO16;
   endproperty
   property p_link01;
      csh[0][5] |-> chan_pin_oe_o[0] && !chan_pin_oe_o[1] && !chan_irq_o[1];
   endproperty
   property p_link23;
      csh[2][5] |-> chan_pin_oe_o[2] && !chan_pin_oe_o[3] && !chan_irq_o[3];
   endproperty
   property p_link45;
      csh[4][5] |-> chan_pin_oe_o[4] && !chan_pin_oe_o[5] && !chan_irq_o[5];
   endproperty
   property p_ovf_tog;
      $rose(ovf_irq_o) && $past(ovie) && $past(csh[0][4:0]) == 5'h1A
         |-> chan_pin_o[0] != $past(chan_pin_o[0]);
   endproperty
   property p_cmp_clr;
      $rose(chan_irq_o[0]) && $past(csh[0][6]) && $past(csh[0][3:2]) == 2'b10
         |-> !chan_pin_o[0];
   endproperty
   property p_no_tov;
      csh[0][4:0] == 5'h18 && !chan_pin_o[0] |=> !chan_pin_o[0];
   endproperty
   property p_max_hold;
      csh[0][4:0] == 5'h1B && chan_pin_o[0] |=> chan_pin_o[0] [*2];
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   a_link01: assert property (p_link01) else $error("pair 0/1 pin ownership wrong");
   a_link23: assert property (p_link23) else $error("pair 2/3 pin ownership wrong");
   a_link45: assert property (p_link45) else $error("pair 4/5 pin ownership wrong");
   a_ovf_tog: assert property (p_ovf_tog) else $error("no pin toggle at overflow");
   a_cmp_clr: assert property (p_cmp_clr) else $error("flag without pin clear");
   a_no_tov: assert property (p_no_tov) else $error("pin left low level");
   a_max_hold: assert property (p_max_hold) else $error("full duty pin dropped");
   c_ovf: cover property ($rose(ovf_irq_o));
   c_cmp: cover property ($rose(chan_irq_o[0]));
   c_link: cover property (csh[4][5] && chan_pin_o[4]);
endmodule : tcp_top_asserts

bind tcp_top tcp_top_asserts tcp_top_asserts_inst (
   .sys_clk_i(sys_clk_i),
   .nrst_i(nrst_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .chan_pin_o(chan_pin_o),
   .chan_pin_oe_o(chan_pin_oe_o),
   .ovf_irq_o(ovf_irq_o),
   .chan_irq_o(chan_irq_o)
);

// ---- verification/tcp_top_bench.sv ----
// self-checking bench for the timer compare/pwm output block
`timescale 1ns/100ps
module tcp_top_bench
   import tcp_pkg::*;
;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] addr = '0;
   logic [15:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic [5:0] pin;
   logic [5:0] pin_oe;
   logic ovf_irq;
   logic [5:0] chan_irq;
   int err_count = 0;
   int check_count = 0;
   int h;
   int l;
   logic [15:0] tc_val [2] = '{16'h0022, 16'h0026};
   logic [15:0] act_val [3] = '{16'h0001, 16'h0002, 16'h0004};
   always #10 sys_clk = ~sys_clk;
   tcp_top tcp_top_inst (
      .sys_clk_i(sys_clk),
      .nrst_i(nrst),
      .addr_i(addr),
      .wdata_i(wdata),
      .wr_i(wr),
      .rd_i(rd),
      .rdata_o(rdata),
      .chan_pin_o(pin),
      .chan_pin_oe_o(pin_oe),
      .ovf_irq_o(ovf_irq),
      .chan_irq_o(chan_irq)
   );
   // ------------
   // shared tasks
   // ------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_len(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         err_count++;
         $display("mismatch at %0t: length %0d expected %0d", $time, got, exp);
      end
   endtask : chk_len
   task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : bus_rd
   // counts cycles while the pin holds a level; bounded so a stuck pin ends it
   task automatic run_len(input int b, input logic lvl, output int n);
      n = 0;
      #1;
      while (pin[b] === lvl && n < 1200) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask : run_len
   task automatic pulse(input int b, output int hi, output int lo);
      int x;
      run_len(b, 1'b1, x);
      run_len(b, 1'b0, x);
      run_len(b, 1'b1, hi);
      run_len(b, 1'b0, lo);
   endtask : pulse
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   // -----
   // tests
   // -----
   initial begin
      repeat (40000) @(posedge sys_clk);
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      bus_rd(TCP_OFS_TIMER_CTRL, 16'h0001);
      bus_rd(TCP_OFS_MODULO, TCP_MOD_RST);
      bus_rd(5'h1F, TCP_ZERO16);
      $display("test reset values done");
      bus_wr(TCP_OFS_MODULO, 16'h00FF);
      bus_wr(TCP_OFS_CH_VAL, 16'h0080);
      bus_wr(TCP_OFS_CH_CTRL, 16'h001A);
      for (int ps = 0; ps < 2; ps++) begin
         bus_wr(TCP_OFS_TIMER_CTRL, tc_val[ps]);
         pulse(0, h, l);
         chk_len(h, 128 << ps);
         chk_len(h + l, 256 << ps);
      end
      chk({15'h0000, ovf_irq}, TCP_ONE16);
      bus_wr(TCP_OFS_TIMER_STAT, TCP_ZERO16);
      #1;
      chk({15'h0000, ovf_irq}, TCP_ZERO16);
      $display("test unbuffered pwm done");
      bus_wr(TCP_OFS_CH_CTRL, 16'h0018);
      run_len(0, 1'b1, h);
      run_len(0, 1'b0, h);
      chk_len(h, 1200);
      bus_wr(TCP_OFS_CH_CTRL, 16'h001B);
      run_len(0, 1'b0, h);
      run_len(0, 1'b1, h);
      chk_len(h, 1200);
      bus_wr(TCP_OFS_TIMER_CTRL, tc_val[0]);
      $display("test zero and full duty done");
      for (int p = 0; p < 6; p += 2) begin
         bus_wr(TCP_OFS_CH_VAL + 5'(p), 16'h0040);
         bus_wr(TCP_OFS_CH_CTRL + 5'(p + 1), 16'h0012);
         bus_wr(TCP_OFS_CH_CTRL + 5'(p), 16'h007A);
         pulse(p, h, l);
         chk_len(h, 64);
         chk({15'h0000, pin_oe[p + 1]}, TCP_ZERO16);
         chk({15'h0000, chan_irq[p]}, TCP_ONE16);
         bus_wr(TCP_OFS_CH_VAL + 5'(p + 1), 16'h00C0);
         bus_rd(TCP_OFS_ACTIVE, TCP_ZERO16);
         pulse(p, h, l);
         chk_len(h, 192);
         bus_rd(TCP_OFS_ACTIVE, act_val[p / 2]);
         bus_wr(TCP_OFS_CH_VAL + 5'(p), 16'h0020);
         pulse(p, h, l);
         chk_len(h, 32);
         bus_wr(TCP_OFS_CH_CTRL + 5'(p), TCP_ZERO16);
      end
      $display("test linked pairs done");
      bus_wr(TCP_OFS_CH_VAL, 16'h0040);
      bus_wr(TCP_OFS_CH_CTRL, 16'h001E);
      pulse(0, h, l);
      chk_len(l, 64);
      chk_len(h + l, 256);
      bus_wr(TCP_OFS_TIMER_CTRL, 16'h0003);
      bus_rd(TCP_OFS_COUNT, TCP_ZERO16);
      $display("test low pulse and stop done");
      give_verdict();
   end
endmodule : tcp_top_bench
